// >>> design/bsa_consts.vh
`ifndef BSA_CONSTS_VH
`define BSA_CONSTS_VH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define BSA_OFF_INSTR   8'h00
`define BSA_OFF_OPND    8'h04
`define BSA_OFF_CMD     8'h08
`define BSA_OFF_STATUS  8'h0c

// ----------------------------------------------------------------
// instruction register fields
// ----------------------------------------------------------------
`define BSA_SRC_LSB     0
`define BSA_SRC_MSB     2
`define BSA_FUNC_LSB    3
`define BSA_FUNC_MSB    5
`define BSA_DEST_LSB    6
`define BSA_DEST_MSB    8
`define BSA_CARRY_BIT   9
`define BSA_INSTR_W     10

// ----------------------------------------------------------------
// operand register fields, four bits each
// ----------------------------------------------------------------
`define BSA_OPA_LSB     0
`define BSA_OPB_LSB     4
`define BSA_OPQ_LSB     8
`define BSA_OPD_LSB     12
`define BSA_OPND_W      16
`define BSA_NIB_W       4

// ----------------------------------------------------------------
// command and status fields
// ----------------------------------------------------------------
`define BSA_CMD_START   0
`define BSA_ST_COUT     4
`define BSA_ST_DONE     5
`define BSA_ST_BUSY     6

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define BSA_INSTR_RST   10'h000
`define BSA_OPND_RST    16'h0000
`define BSA_NIB_RST     4'h0

// ----------------------------------------------------------------
// source select codes
// ----------------------------------------------------------------
`define BSA_SRC_AQ      3'h0
`define BSA_SRC_AB      3'h1
`define BSA_SRC_ZQ      3'h2
`define BSA_SRC_ZB      3'h3
`define BSA_SRC_ZA      3'h4
`define BSA_SRC_DA      3'h5
`define BSA_SRC_DQ      3'h6
`define BSA_SRC_DZ      3'h7

// ----------------------------------------------------------------
// function select codes
// ----------------------------------------------------------------
`define BSA_FN_ADD      3'h0
`define BSA_FN_SUBR     3'h1
`define BSA_FN_SUBS     3'h2
`define BSA_FN_OR       3'h3
`define BSA_FN_AND      3'h4
`define BSA_FN_NOTRS    3'h5
`define BSA_FN_XOR      3'h6
`define BSA_FN_XNOR     3'h7

`endif

// >>> design/bsa_alu.v
`include "bsa_consts.vh"

module bsa_alu (
  // clock and reset
  input  wire       hclk,
  input  wire       hresetn,
  // operation request
  input  wire       calc_en,
  input  wire [2:0] func_sel,
  input  wire       carry_input,
  input  wire [3:0] opr_r,
  input  wire [3:0] opr_s,
  // registered result
  output reg  [3:0] alu_y,
  output reg        alu_cout
);

  reg [4:0] next_sum;
  reg [3:0] next_y;
  reg       next_cout;

  // ----------------------------------------------------------------
  // function decode
  // ----------------------------------------------------------------

  always @*
  begin
    next_sum  = 5'h00;
    next_y    = 4'h0;
    next_cout = 1'b0;
    case (func_sel)
      `BSA_FN_ADD:
      begin
        next_sum  = {1'b0, opr_r} + {1'b0, opr_s} + {4'h0, carry_input};
        next_y    = next_sum[3:0];
        next_cout = next_sum[4];
      end
      `BSA_FN_SUBR:
      begin
        next_sum  = {1'b0, opr_s} + {1'b0, ~opr_r} + {4'h0, carry_input};
        next_y    = next_sum[3:0];
        next_cout = next_sum[4];
      end
      // zero minus pairs complement or negate
      `BSA_FN_SUBS:
      begin
        next_sum  = {1'b0, opr_r} + {1'b0, ~opr_s} + {4'h0, carry_input};
        next_y    = next_sum[3:0];
        next_cout = next_sum[4];
      end
      `BSA_FN_OR:    next_y = opr_r | opr_s;
      `BSA_FN_AND:   next_y = opr_r & opr_s;
      `BSA_FN_NOTRS: next_y = ~opr_r & opr_s;
      `BSA_FN_XOR:   next_y = opr_r ^ opr_s;
      `BSA_FN_XNOR:  next_y = ~(opr_r ^ opr_s);
      default:       next_y = 4'h0;
    endcase
  end

  // result register, loaded once per operation
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      alu_y    <= `BSA_NIB_RST;
      alu_cout <= 1'b0;
    end
    else if (calc_en)
    begin
      alu_y    <= next_y;
      alu_cout <= next_cout;
    end
  end

endmodule // bsa_alu

// >>> design/bsa_top.v
// Decided for this implementation: register access over AHB-Lite and the register offsets.
`include "bsa_consts.vh"

// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
// 0x00 instruction: source [2:0], function [5:3], carry input [9]
//      destination [8:6] is stored and read back, not acted on
// 0x04 operands: a [3:0], b [7:4], q [11:8], direct data [15:12]
// 0x08 command: writing bit 0 high starts one operation, reads zero
// 0x0c status: result [3:0], carry out [4], done [5], busy [6]
// unmapped offsets read zero and ignore writes; no wait states
// a start snapshots instruction and operands, so software may stage
// the next pair while the current result is formed
// the result pins trail the status word by one clock

module bsa_top (
  // clock and reset
  input  wire        hclk,
  input  wire        hresetn,
  // ahb-lite slave
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire        hready,
  input  wire [31:0] hwdata,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  // alu result pins
  output reg  [3:0]  alu_y,
  output reg         alu_cout,
  output reg         alu_done
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  reg  [`BSA_INSTR_W-1:0] instr;      // live instruction word
  reg  [`BSA_OPND_W-1:0]  opnd;       // live operand word
  reg  [`BSA_INSTR_W-1:0] lat_instr;  // instruction held for the op
  reg  [`BSA_OPND_W-1:0]  lat_opnd;   // operands held for the op
  reg                     pend;       // operation in flight
  reg                     done;       // result is current
  reg                     wr_pend;    // write data phase follows
  reg  [7:0]              wr_addr;    // address of that write
  reg  [3:0]              opr_r;
  reg  [3:0]              opr_s;
  reg  [31:0]             next_rdata;
  wire                    bus_go;
  wire                    rd_go;
  wire                    wr_go;
  wire                    start;
  wire [2:0]              src_sel;
  wire [2:0]              func_sel;
  wire                    carry_input;
  wire [3:0]              nib_a;
  wire [3:0]              nib_b;
  wire [3:0]              nib_q;
  wire [3:0]              nib_d;
  wire [3:0]              core_y;
  wire                    core_cout;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------

  // hsize is not checked: every access is taken as a whole word
  // an accepted address phase of a real transfer
  assign bus_go = hsel & hready & htrans[1];
  assign rd_go  = bus_go & ~hwrite;
  assign wr_go  = wr_pend;

  // write of the start bit to the command register
  assign start = wr_go && (wr_addr == `BSA_OFF_CMD) && hwdata[`BSA_CMD_START];

  // address phase capture for writes
  // only address bits 7:2 are decoded, higher bits alias
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
    end
    else
    begin
      wr_pend <= bus_go & hwrite;
      if (bus_go & hwrite)
        wr_addr <= {haddr[7:2], 2'b00};
    end
  end

  // zero wait states, always okay
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // software registers
  // ----------------------------------------------------------------

  // instruction and operand words, written in the data phase
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      instr <= `BSA_INSTR_RST;
      opnd  <= `BSA_OPND_RST;
    end
    else if (wr_go)
    begin
      if (wr_addr == `BSA_OFF_INSTR)
        instr <= hwdata[`BSA_INSTR_W-1:0];
      if (wr_addr == `BSA_OFF_OPND)
        opnd <= hwdata[`BSA_OPND_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // operand latch
  // ----------------------------------------------------------------

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      lat_instr <= `BSA_INSTR_RST;
      lat_opnd  <= `BSA_OPND_RST;
    end
    else if (start)
    begin
      lat_instr <= instr;
      lat_opnd  <= opnd;
    end
  end

  // operation progress flags
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pend <= 1'b0;
      done <= 1'b0;
    end
    else
    begin
      pend <= start;
      // a start beside a finishing op clears done: the new op owns the result
      if (start)
        done <= 1'b0;
      else if (pend)
        done <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // source operand selection
  // ----------------------------------------------------------------

  assign src_sel     = lat_instr[`BSA_SRC_MSB:`BSA_SRC_LSB];
  assign func_sel    = lat_instr[`BSA_FUNC_MSB:`BSA_FUNC_LSB];
  assign carry_input = lat_instr[`BSA_CARRY_BIT];

  assign nib_a = lat_opnd[`BSA_OPA_LSB +: `BSA_NIB_W];
  assign nib_b = lat_opnd[`BSA_OPB_LSB +: `BSA_NIB_W];
  assign nib_q = lat_opnd[`BSA_OPQ_LSB +: `BSA_NIB_W];
  assign nib_d = lat_opnd[`BSA_OPD_LSB +: `BSA_NIB_W];

  always @*
  begin
    opr_r = 4'h0;
    opr_s = 4'h0;
    case (src_sel)
      `BSA_SRC_AQ:
      begin
        opr_r = nib_a;
        opr_s = nib_q;
      end
      `BSA_SRC_AB:
      begin
        opr_r = nib_a;
        opr_s = nib_b;
      end
      `BSA_SRC_ZQ: opr_s = nib_q;
      `BSA_SRC_ZB: opr_s = nib_b;
      `BSA_SRC_ZA: opr_s = nib_a;
      `BSA_SRC_DA:
      begin
        opr_r = nib_d;
        opr_s = nib_a;
      end
      `BSA_SRC_DQ:
      begin
        opr_r = nib_d;
        opr_s = nib_q;
      end
      `BSA_SRC_DZ: opr_r = nib_d;
      default:
      begin
        opr_r = 4'h0;
        opr_s = 4'h0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // function unit
  // ----------------------------------------------------------------

  // function codes decoded in the core
  bsa_alu u_alu (
    .hclk        (hclk),
    .hresetn     (hresetn),
    .calc_en     (pend),
    .func_sel    (func_sel),
    .carry_input (carry_input),
    .opr_r       (opr_r),
    .opr_s       (opr_s),
    .alu_y       (core_y),
    .alu_cout    (core_cout)
  );

  // result pins follow the core result
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      alu_y    <= `BSA_NIB_RST;
      alu_cout <= 1'b0;
      alu_done <= 1'b0;
    end
    else
    begin
      alu_y    <= core_y;
      alu_cout <= core_cout;
      alu_done <= done;
    end
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------

  // read mux, unmapped addresses read zero
  // status shows the core result, one clock ahead of the pins
  always @*
  begin
    next_rdata = 32'h0000_0000;
    case ({haddr[7:2], 2'b00})
      `BSA_OFF_INSTR:  next_rdata[`BSA_INSTR_W-1:0] = instr;
      `BSA_OFF_OPND:   next_rdata[`BSA_OPND_W-1:0]  = opnd;
      `BSA_OFF_STATUS:
      begin
        next_rdata[3:0]          = core_y;
        next_rdata[`BSA_ST_COUT] = core_cout;
        next_rdata[`BSA_ST_DONE] = done;
        next_rdata[`BSA_ST_BUSY] = pend;
      end
      default:         next_rdata = 32'h0000_0000;
    endcase
  end

  // read data registered into the data phase
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h0000_0000;
    else if (rd_go)
      hrdata <= next_rdata;
  end

endmodule // bsa_top

// >>> sim/bsa_chk.sv
// ----
// bus and result checker
// ----
module bsa_chk (
  // clock and reset
  input wire        hclk,
  input wire        hresetn,
  // bus
  input wire        hsel,
  input wire [31:0] haddr,
  input wire [1:0]  htrans,
  input wire        hwrite,
  input wire        hready,
  input wire [31:0] hwdata,
  input wire [31:0] hrdata,
  input wire        hreadyout,
  input wire        hresp,
  // result pins
  input wire [3:0]  alu_y,
  input wire        alu_cout,
  input wire        alu_done
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  wire       take = hsel & hready & htrans[1];
  wire       rd_a = take & !hwrite;
  reg        wr_cmd;
  reg        wr_ins;
  reg        start_q;
  reg  [2:0] fn;
  wire       start = wr_cmd & hwdata[0];
  // data phases of command and instruction writes
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_cmd <= 1'b0;
      wr_ins <= 1'b0;
      start_q <= 1'b0;
      fn <= 3'h0;
    end
    else
    begin
      wr_cmd <= take & hwrite & (haddr[7:2] == 6'h02);
      wr_ins <= take & hwrite & (haddr[7:2] == 6'h00);
      start_q <= start;
      if (wr_ins)
        fn <= hwdata[5:3];
    end
  end
  ready_okay_a: assert property (hreadyout && !hresp)
    else $error("bus not ready or not okay");
  reset_clear_a: assert property ($rose(hresetn) |-> !alu_done && alu_y == 4'h0 && hrdata == 32'h0)
    else $error("outputs not clear after reset");
  done_timing_a: assert property (start |-> ##2 !alu_done ##1 alu_done)
    else $error("done pin timing wrong");
  result_hold_a: assert property (alu_done && !start && !start_q |=>
    $stable(alu_y) && $stable(alu_cout) && alu_done)
    else $error("result moved without start");
  logic_nocarry_a: assert property (start && fn >= 3'h3 |-> ##3 !alu_cout)
    else $error("carry out on logic op");
  read_zero_a: assert property (rd_a && (haddr[7:2] == 6'h02 || haddr[7:2] > 6'h03)
    |=> hrdata == 32'h0)
    else $error("write-only or unmapped read not zero");
  read_upper_a: assert property (rd_a |=> hrdata[31:16] == 16'h0)
    else $error("upper read bits set");
  status_match_a: assert property (rd_a && haddr[7:2] == 6'h03 && alu_done && !start
    && !start_q |=> hrdata[6:0] == {2'b01, alu_cout, alu_y})
    else $error("status disagrees with pins");
  cover property (start ##3 alu_done);
  cover property (start && fn == 3'h1);
  cover property (rd_a && haddr[7:2] > 6'h03);
endmodule // bsa_chk

bind bsa_top bsa_chk u_chk (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .alu_y(alu_y), .alu_cout(alu_cout),
  .alu_done(alu_done)
);

// >>> sim/bsa_ahb_mst.sv
// ----
// controller side: single word bus master
// ----
module bsa_ahb_mst (
  // clock
  input  wire         hclk,
  // master outputs
  output logic        hsel,
  output logic [31:0] haddr,
  output logic [1:0]  htrans,
  output logic        hwrite,
  output logic [2:0]  hsize,
  output logic [31:0] hwdata,
  // slave answer
  input  wire         hready,
  input  wire  [31:0] hrdata
);
  timeunit 1ns;
  timeprecision 100ps;
  // idle bus at time zero
  initial
  begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end
  // one transfer, entered just after a rising edge
  task xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
            output logic [31:0] r);
    begin
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      @(posedge hclk);
      while (hready !== 1'b1)
        @(posedge hclk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      haddr <= ~a;
      hwdata <= w ? d : ~hwdata;
      @(posedge hclk);
      while (hready !== 1'b1)
        @(posedge hclk);
      r = hrdata;
      hwdata <= ~hwdata;
    end
  endtask
endmodule // bsa_ahb_mst

// >>> sim/test_bit_slice_alu_operand_function.sv
`include "bsa_consts.vh"

module test_bit_slice_alu_operand_function;
  timeunit 1ns;
  timeprecision 100ps;
  // bus and pins
  logic        hclk;
  logic        hresetn;
  wire         hsel;
  wire  [31:0] haddr;
  wire  [1:0]  htrans;
  wire         hwrite;
  wire  [2:0]  hsize;
  wire  [31:0] hwdata;
  wire  [31:0] hrdata;
  wire         hreadyout;
  wire         hresp;
  wire  [3:0]  alu_y;
  wire         alu_cout;
  wire         alu_done;
  int          num_errors;
  int          n_tests;
  int          cycles;
  logic [15:0] seed;
  logic [31:0] rd;

  bsa_top DUT (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .alu_y(alu_y),
    .alu_cout(alu_cout), .alu_done(alu_done)
  );
  bsa_ahb_mst m (
    .hclk(hclk), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata)
  );

  // 200 mhz clock
  initial
  begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end
  // hang guard
  always @(posedge hclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 40000)
    begin
      num_errors = num_errors + 1;
      results();
    end
  end

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // expected {carry out, result}
  function automatic logic [4:0] exp_alu(input logic [2:0] src, input logic [2:0] fn,
                                         input logic c, input logic [15:0] o);
    logic [3:0] r;
    logic [3:0] s;
    begin
      r = (src < 3'h2) ? o[3:0] : ((src < 3'h5) ? 4'h0 : o[15:12]);
      case (src)
        3'h0, 3'h2, 3'h6: s = o[11:8];
        3'h1, 3'h3: s = o[7:4];
        3'h4, 3'h5: s = o[3:0];
        default: s = 4'h0;
      endcase
      case (fn)
        3'h0: exp_alu = r + s + c;
        3'h1: exp_alu = s + {1'b0, ~r} + c;
        3'h2: exp_alu = r + {1'b0, ~s} + c;
        3'h3: exp_alu = {1'b0, r | s};
        3'h4: exp_alu = {1'b0, r & s};
        3'h5: exp_alu = {1'b0, ~r & s};
        3'h6: exp_alu = {1'b0, r ^ s};
        default: exp_alu = {1'b0, ~(r ^ s)};
      endcase
    end
  endfunction

  task chk(input logic [31:0] got, input logic [31:0] exp);
    begin
      n_tests = n_tests + 1;
      if (got !== exp)
      begin
        num_errors = num_errors + 1;
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    m.xfer(1'b1, {24'h0, a}, d, rd);
  endtask
  task rdc(input logic [7:0] a, input logic [31:0] e);
    begin
      m.xfer(1'b0, {24'h0, a}, 32'h0, rd);
      chk(rd, e);
    end
  endtask
  // start one operation, disturb its inputs, poll and compare
  task run_op(input logic [2:0] src, input logic [2:0] fn, input logic c,
              input logic [15:0] o);
    logic [4:0] e;
    int         k;
    begin
      e = exp_alu(src, fn, c, o);
      wr(`BSA_OFF_INSTR, {22'h0, c, seed[2:0], fn, src});
      wr(`BSA_OFF_OPND, {16'h0, o});
      wr(`BSA_OFF_CMD, 32'h1);
      wr(`BSA_OFF_OPND, {16'h0, ~o});
      wr(`BSA_OFF_INSTR, {22'h0, ~c, seed[2:0], ~fn, ~src});
      rd = 32'h0;
      for (k = 0; k < 8 && rd[`BSA_ST_DONE] !== 1'b1; k++)
        m.xfer(1'b0, {24'h0, `BSA_OFF_STATUS}, 32'h0, rd);
      chk(rd, {25'h0, 2'b01, e});
      chk({27'h0, alu_cout, alu_y}, {27'h0, e});
      chk({31'h0, alu_done}, 32'h1);
    end
  endtask
  task results;
    begin
      if (num_errors == 0 && n_tests > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask

  // main sequence
  initial
  begin
    hresetn = 1'b0;
    seed = 16'h0004;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rdc(`BSA_OFF_INSTR, 32'h0);
    rdc(`BSA_OFF_STATUS, 32'h0);
    wr(8'h10, 32'hffffffff);
    rdc(8'h10, 32'h0);
    wr(`BSA_OFF_CMD, 32'h0);
    rdc(`BSA_OFF_CMD, 32'h0);
    wr(`BSA_OFF_INSTR, 32'hffffffff);
    rdc(`BSA_OFF_INSTR, 32'h3ff);
    wr(`BSA_OFF_OPND, 32'hffffffff);
    rdc(`BSA_OFF_OPND, 32'hffff);
    // all sources, functions and carries: full, empty, then random operands
    for (int p = 0; p < 3; p++)
      for (int i = 0; i < 128; i++)
      begin
        seed = lfsr(seed);
        run_op(i[2:0], i[5:3], i[6], p == 0 ? 16'hffff : (p == 1 ? 16'h0 : seed));
      end
    // reset in mid run clears the pins
    hresetn <= 1'b0;
    @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk({26'h0, alu_cout, alu_y, alu_done}, 32'h0);
    rdc(`BSA_OFF_STATUS, 32'h0);
    results();
  end
endmodule // test_bit_slice_alu_operand_function
